// [rtl/search_engine_write_port.sv]
`timescale 1ns/1ps
`include "swp_params.svh"
// Function
// - command bit two selects single or burst
// - single write is command, data, idle
// - accept only matching or broadcast identifier
// - data follows command, idle before next
// - bus bits 20:19 pick the target
// - indirect address from indexed result register
// - direct address from bus bits 15:0
// - register address from bus bits 6:0
// - burst lasts n plus two cycles
// - burst uses incrementing internal address
// - array bits written only where mask set
// - end-of-transfer low, high last, low, released
// - parallel write uses bits 10:1, 1024 entries
module search_engine_write_port
    import swp_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        command_valid_in,
    input  wire logic [10:0] cmd_in,
    input  wire logic [71:0] dq_in,
    output logic [71:0]      dq_out,
    output logic             dq_oe_n_out,
    output logic             end_of_transfer_out,
    output logic             end_of_transfer_oe_n_out,
    input  wire logic [4:0]  device_identifier_in,
    output logic             wr_valid_out,
    input  wire logic        wr_ready_in,
    output logic [1:0]       wr_target_out,
    output logic [15:0]      wr_addr_out,
    output logic [71:0]      wr_data_out,
    output logic [71:0]      wr_mask_out,
    output logic             wr_parallel_out,
    output logic [2:0]       sram_address_hi_out,
    output logic             port_ready_out,
    output logic             busy_out,
    output logic             overflow_out
);
    localparam int unsigned BW = 166;   // packed write word

    port_state_t r, n;          // all state
    logic        cmd_write;     // synced write opcode present
    logic        id_hit;        // this device addressed
    logic [7:0]  burst_length;          // burst length field
    logic [BW-1:0] buf_in;      // word into the buffer
    logic [BW-1:0] buf_out;     // word out of the buffer
    logic        buf_ready;     // buffer has room

    assign cmd_write = r.cv_s2 && (r.cmd_s2[1:0] == `OP_WRITE);
    assign id_hit = (r.dq_s2[`DQ_ID_LSB +: 5] == r.id_s2) ||
                    (r.dq_s2[`DQ_ID_LSB +: 5] == `ALL_DEVICES);
    assign burst_length = r.bctl[`BCTL_LEN_LSB +: 8];

    // write port never drives the data bus
    assign dq_out = 72'h00_0000_0000_0000_0000;
    assign dq_oe_n_out = 1'b1;
    assign end_of_transfer_out = r.eot_v;
    assign end_of_transfer_oe_n_out = r.eot_oe_n;
    assign busy_out = (r.st != ST_IDLE);
    assign overflow_out = r.ovf;
    assign port_ready_out = buf_ready;
    assign buf_in = {r.pt, r.pa, r.pd, r.pm, r.pp, r.ph};
    assign {wr_target_out, wr_addr_out, wr_data_out, wr_mask_out,
            wr_parallel_out, sram_address_hi_out} = buf_out;

    // sequencer and register file next state
    always_comb begin
        n = r;
        // two-stage pin synchronisers
        n.cv_s1  = command_valid_in;
        n.cv_s2  = r.cv_s1;
        n.cmd_s1 = cmd_in;
        n.cmd_s2 = r.cmd_s1;
        n.dq_s1  = dq_in;
        n.dq_s2  = r.dq_s1;
        n.id_s1  = device_identifier_in;
        n.id_s2  = r.id_s1;
        // defaults: no push, line released
        n.pv = 1'b0;
        n.eot_v = 1'b0;
        n.eot_oe_n = 1'b1;
        // word refused by a full buffer is flagged
        if (r.pv && !buf_ready) begin
            n.ovf = 1'b1;
        end
        case (r.st)
            // phase A: capture command fields
            ST_IDLE: begin
                if (cmd_write) begin
                    n.gidx  = {r.cmd_s2[`CMD_GIDX_HI], r.cmd_s2[`CMD_GIDX_LSB +: 3]};
                    n.shi   = r.cmd_s2[`CMD_SHI_LSB +: 3];
                    n.par   = r.cmd_s2[`CMD_PAR];
                    n.burst = r.cmd_s2[`CMD_BURST];
                    n.st    = ST_PHB;
                end
            end
            // phase B: decode address word
            ST_PHB: begin
                if (!cmd_write) begin
                    n.st = ST_IDLE;
                end else begin
                    n.sel   = id_hit;
                    n.tgt   = r.dq_s2[`DQ_TGT_LSB +: 2];
                    n.raddr = r.dq_s2[6:0];
                    // parallel only when set in both phases, arrays only
                    n.par = r.par && r.cmd_s2[`CMD_PAR] && !r.dq_s2[`DQ_TGT_LSB + 1];
                    if (r.dq_s2[`DQ_IND]) begin
                        n.addr = {r.search_result_reg[r.dq_s2[`DQ_SSR_LSB +: 3]][15:2],
                                  r.search_result_reg[r.dq_s2[`DQ_SSR_LSB +: 3]][1] | r.dq_s2[1],
                                  r.search_result_reg[r.dq_s2[`DQ_SSR_LSB +: 3]][0] | r.dq_s2[0]};
                    end else begin
                        n.addr = r.dq_s2[15:0];
                    end
                    if (r.burst) begin
                        // burst only reaches the arrays
                        n.sel  = id_hit && !r.dq_s2[`DQ_TGT_LSB + 1];
                        n.par  = 1'b0;
                        n.wcnt = 8'h01;
                        n.st   = (burst_length == 8'h00) ? ST_GAP : ST_BURST;
                    end else begin
                        n.st = ST_DATA;
                    end
                end
            end
            // single data cycle
            ST_DATA: begin
                if (r.sel && (r.tgt == `TGT_REG)) begin
                    // internal register write, unmasked
                    if (r.raddr < `REG_SSR_BASE) begin
                        n.global_mask_reg[r.raddr[3:0]] = r.dq_s2;
                    end else if (r.raddr < `REG_BCTL) begin
                        n.search_result_reg[r.raddr[2:0]] = r.dq_s2[15:0];
                    end else if (r.raddr == `REG_BCTL) begin
                        n.bctl = r.dq_s2[31:0];
                    end
                end else if (r.sel) begin
                    n.pv = 1'b1;
                    n.pt = r.tgt;
                    n.pd = r.dq_s2;
                    n.pp = r.par;
                    n.ph = r.shi;
                    // parallel form keeps only the in-partition index
                    n.pa = r.par ? {5'h00, r.addr[10:1], 1'b0} : r.addr;
                    n.pm = r.tgt[1] ? `FULL_MASK : r.global_mask_reg[r.gidx];
                end
                n.st = ST_GAP;
            end
            // one burst word per cycle
            ST_BURST: begin
                if (r.sel) begin
                    n.pv = 1'b1;
                    n.pt = r.tgt;
                    n.pd = r.dq_s2;
                    n.pp = 1'b0;
                    n.ph = r.shi;
                    n.pa = r.bctl[15:0];
                    n.pm = r.global_mask_reg[r.gidx];
                    n.bctl[15:0] = r.bctl[15:0] + 16'h0001;
                    // driven from the second word and on the last, high on the last
                    if ((r.wcnt >= 8'h02) || (r.wcnt == burst_length)) begin
                        n.eot_oe_n = 1'b0;
                        n.eot_v = (r.wcnt == burst_length);
                    end
                end
                if (r.wcnt == burst_length) begin
                    n.st = ST_TAIL;
                end else begin
                    n.wcnt = r.wcnt + 8'h01;
                end
            end
            // closing cycle drives low once more
            ST_TAIL: begin
                if (r.sel) begin
                    n.eot_oe_n = 1'b0;
                end
                n.st = ST_IDLE;
            end
            // idle cycle before the next command
            ST_GAP: begin
                n.st = ST_IDLE;
            end
            default: begin
                n.st = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r <= '0;
            r.global_mask_reg <= {16{`GMR_RST}};
            r.eot_oe_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // two-entry buffer toward the arrays
    swp_buffer #(
        .W     (BW),
        .DEPTH (2)
    ) u_buf (
        .core_clk_in   (core_clk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (r.pv),
        .in_ready_out  (buf_ready),
        .in_data_in    (buf_in),
        .out_valid_out (wr_valid_out),
        .out_ready_in  (wr_ready_in),
        .out_data_out  (buf_out)
    );

    // checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_single_tail;
        (r.st == ST_DATA) ##1 (r.st == ST_GAP) ##1 (r.st == ST_IDLE);
    endsequence
    sequence s_eot_close;
        (r.eot_v && !r.eot_oe_n) ##1 (!r.eot_v && !r.eot_oe_n) ##1 r.eot_oe_n;
    endsequence

    property p_single;
        (r.st == ST_PHB && cmd_write && !r.burst) |=> s_single_tail;
    endproperty
    a_single: assert property (p_single) else $error("single write not three cycles");

    property p_select;
        (r.st == ST_PHB && cmd_write && !id_hit) |=> ##1 !r.pv;
    endproperty
    a_select: assert property (p_select) else $error("write to unselected device");

    property p_target;
        (r.st == ST_DATA && r.sel && r.tgt != `TGT_REG) |=> (r.pv && r.pt == $past(r.tgt));
    endproperty
    a_target: assert property (p_target) else $error("target not passed on");

    property p_direct;
        (r.st == ST_PHB && cmd_write && !r.burst && id_hit && !r.dq_s2[`DQ_IND] &&
         r.dq_s2[`DQ_TGT_LSB +: 2] != `TGT_REG)
        |=> ##1 (r.pp || r.pa == $past(r.dq_s2[15:0], 2));
    endproperty
    a_direct: assert property (p_direct) else $error("direct address wrong");

    property p_regwr;
        (r.st == ST_DATA && r.sel && r.tgt == `TGT_REG && r.raddr == `REG_BCTL)
        |=> (r.bctl == $past(r.dq_s2[31:0]));
    endproperty
    a_regwr: assert property (p_regwr) else $error("register write lost");

    property p_mask;
        (r.pv && !r.pt[1]) |-> (r.pm == r.global_mask_reg[r.gidx]);
    endproperty
    a_mask: assert property (p_mask) else $error("array write mask wrong");

    property p_incr;
        (r.st == ST_BURST && r.sel) |=> (r.bctl[15:0] == $past(r.bctl[15:0]) + 16'h0001);
    endproperty
    a_incr: assert property (p_incr) else $error("burst address not stepped");

    property p_eot_last;
        (r.st == ST_BURST && r.sel && r.wcnt == burst_length) |=> s_eot_close;
    endproperty
    a_eot_last: assert property (p_eot_last) else $error("end of transfer sequence wrong");

    property p_release;
        dq_oe_n_out && (r.eot_oe_n || $past(r.st) == ST_BURST || $past(r.st) == ST_TAIL);
    endproperty
    a_release: assert property (p_release) else $error("pin driven outside burst");
endmodule

// [rtl/swp_buffer.sv]
`timescale 1ns/1ps
// small fifo between the write port and the array side
module swp_buffer #(
    parameter int unsigned W     = 8,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic         core_clk_in,
    input  wire logic         rst_n_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    output logic              out_valid_out,
    input  wire logic         out_ready_in,
    output logic [W-1:0]      out_data_out
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;   // storage
        logic [AW-1:0]           wp;    // write pointer
        logic [AW-1:0]           rp;    // read pointer
        logic [AW:0]             cnt;   // fill level
    } buf_t;

    buf_t r, n;
    logic push, pop;

    // honest full and empty
    assign in_ready_out  = (r.cnt != (AW+1)'(DEPTH));
    assign out_valid_out = (r.cnt != '0);
    assign out_data_out  = r.mem[r.rp];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    // pointer and level update
    always_comb begin
        n = r;
        if (push) begin
            n.mem[r.wp] = in_data_in;
            n.wp = (r.wp == AW'(DEPTH-1)) ? '0 : r.wp + 1'b1;
        end
        if (pop) begin
            n.rp = (r.rp == AW'(DEPTH-1)) ? '0 : r.rp + 1'b1;
        end
        if (push && !pop) begin
            n.cnt = r.cnt + 1'b1;
        end else if (pop && !push) begin
            n.cnt = r.cnt - 1'b1;
        end
    end

    // state register
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule

// [rtl/swp_params.svh]
`ifndef SWP_PARAMS_SVH
`define SWP_PARAMS_SVH
// command field positions and codes
`define OP_WRITE       2'h1
`define CMD_BURST      2
`define CMD_PAR        9
`define CMD_GIDX_HI    10
`define CMD_GIDX_LSB   3
`define CMD_SHI_LSB    6
// data bus field positions
`define DQ_IND         29
`define DQ_SSR_LSB     26
`define DQ_ID_LSB      21
`define DQ_TGT_LSB     19
`define ALL_DEVICES    5'h1f
// write targets
`define TGT_DATA       2'h0
`define TGT_MASK       2'h1
`define TGT_SRAM       2'h2
`define TGT_REG        2'h3
// internal register addresses
`define REG_GMR_BASE   7'h00
`define REG_SSR_BASE   7'h10
`define REG_BCTL       7'h18
// burst control layout
`define BCTL_LEN_LSB   16
// reset and full mask values
`define GMR_RST        72'hff_ffff_ffff_ffff_ffff
`define FULL_MASK      72'hff_ffff_ffff_ffff_ffff
`endif

// [rtl/swp_pkg.sv]
package swp_pkg;
    // write sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_PHB, ST_DATA, ST_BURST, ST_TAIL, ST_GAP
    } wr_state_t;

    // full state of the write port
    typedef struct packed {
        wr_state_t          st;
        logic               cv_s1, cv_s2;
        logic [10:0]        cmd_s1, cmd_s2;
        logic [71:0]        dq_s1, dq_s2;
        logic [4:0]         id_s1, id_s2;
        logic [3:0]         gidx;
        logic [2:0]         shi;
        logic               par;
        logic               burst;
        logic               sel;
        logic [1:0]         tgt;
        logic [15:0]        addr;
        logic [6:0]         raddr;
        logic [15:0][71:0]  global_mask_reg;
        logic [7:0][15:0]   search_result_reg;
        logic [31:0]        bctl;
        logic [7:0]         wcnt;
        logic               eot_v;
        logic               eot_oe_n;
        logic               pv;
        logic [1:0]         pt;
        logic [15:0]        pa;
        logic [71:0]        pd;
        logic [71:0]        pm;
        logic               pp;
        logic [2:0]         ph;
        logic               ovf;
    } port_state_t;
endpackage

// [tb/host_model.sv]
`timescale 1ns/1ps
// host side of the command link, changes its pins just after the falling edge
module host_model (
    input  wire logic   core_clk_in,
    output logic        command_valid_out,
    output logic [10:0] cmd_out,
    output logic [71:0] dq_out
);
    logic [10:0] cmd_word; // command held through both phases
    initial begin
        command_valid_out = 1'b0;
        cmd_out           = 11'h000;
        dq_out            = 72'h00_0000_0000_0000_0000;
    end
    // one bus cycle
    task automatic put(input logic v, input logic [10:0] c, input logic [71:0] d);
        @(negedge core_clk_in);
        command_valid_out = v;
        cmd_out           = c;
        dq_out            = d;
    endtask
    // burst data pattern, one word per index
    function automatic logic [71:0] word(input int i);
        return 72'h5a_0000_0000_0000_0000 + 72'(i);
    endfunction
    // two command phases with the same opcode, mask index and address word
    task automatic phases(input logic b, input logic p, input logic [1:0] t, input logic ind,
        input logic [2:0] si, input logic [15:0] a, input logic [4:0] id,
        input logic [3:0] g, input logic [2:0] sh);
        cmd_word = {g[3], p, sh, g[2:0], b, 2'h1};
        repeat (2) put(1'b1, cmd_word, {42'h000_0000_0000, ind, si, id, t, 3'h0, a});
    endtask
    // single write; a released bus shows the inverse word, not the old one
    task automatic single(input logic p, input logic [1:0] t, input logic ind,
        input logic [2:0] si, input logic [15:0] a, input logic [4:0] id,
        input logic [3:0] g, input logic [2:0] sh, input logic [71:0] d);
        phases(1'b0, p, t, ind, si, a, id, g, sh);
        put(1'b0, ~cmd_word, d);
        put(1'b0, cmd_word, ~d);
    endtask
    // burst write with junk address bits, n words then closing cycles
    task automatic burst(input logic [1:0] t, input logic [4:0] id, input logic [3:0] g,
        input int n);
        phases(1'b1, 1'b0, t, 1'b0, 3'h0, 16'hbeef, id, g, 3'h0);
        for (int i = 0; i < n; i++) begin
            put(1'b0, ~cmd_word, word(i));
        end
        put(1'b0, cmd_word, ~word(n - 1));
        put(1'b0, ~cmd_word, word(n - 1));
    endtask
endmodule

// [tb/test_search_engine_write_port.sv]
`timescale 1ns/1ps
`include "swp_params.svh"
module test_search_engine_write_port;
    localparam logic [4:0]  MY_ID = 5'h0a;                     // strap of this device
    localparam logic [71:0] PAT   = 72'hf0_0f0f_f0f0_0ff0_a5c3; // mask register pattern
    localparam int          LIMIT = 3000;                      // cycle ceiling
    typedef struct packed {
        logic [1:0] t; logic [15:0] a; logic [71:0] d; logic [71:0] m; logic p; logic [2:0] h;
    } wr_ent_t;
    logic        clk, rst_n, cv, wr_ready;
    logic [10:0] cmd;
    logic [71:0] dq, dq_o, wd, wm;
    logic        dq_oe_n, end_of_transfer, eot_oe_n, wv, wp, pr, busy, ovf, dq_bad;
    logic [1:0]  wt;
    logic [15:0] wa;
    logic [2:0]  wh;
    logic [4:0]  dev_id;
    wr_ent_t     got_q[$];  // words taken from the write stream
    logic        eot_q[$];  // end-of-transfer values while driven
    int          n_mismatch, checks_done, cycles;

    search_engine_write_port dut (.core_clk_in(clk), .rst_n_in(rst_n),
        .command_valid_in(cv), .cmd_in(cmd), .dq_in(dq), .dq_out(dq_o), .dq_oe_n_out(dq_oe_n),
        .end_of_transfer_out(end_of_transfer), .end_of_transfer_oe_n_out(eot_oe_n),
        .device_identifier_in(dev_id), .wr_valid_out(wv), .wr_ready_in(wr_ready),
        .wr_target_out(wt), .wr_addr_out(wa), .wr_data_out(wd), .wr_mask_out(wm),
        .wr_parallel_out(wp), .sram_address_hi_out(wh), .port_ready_out(pr),
        .busy_out(busy), .overflow_out(ovf));
    host_model host (.core_clk_in(clk), .command_valid_out(cv), .cmd_out(cmd), .dq_out(dq));

    // clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // stream monitor and hang guard
    always @(posedge clk) begin
        if (wv === 1'b1 && wr_ready === 1'b1) begin
            got_q.push_back({wt, wa, wd, wm, wp, wh});
        end
        cycles++;
        if (cycles >= LIMIT) begin
            n_mismatch++;
            wrap_up();
        end
    end
    // pin watcher, settled values
    always @(negedge clk) begin
        if (eot_oe_n === 1'b0) begin
            eot_q.push_back(end_of_transfer);
        end
        if (rst_n === 1'b1 && (dq_oe_n !== 1'b1 || dq_o !== 72'h00_0000_0000_0000_0000)) begin
            dq_bad = 1'b1;
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [71:0] e, input logic [71:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // bounded wait for n stream words
    task automatic wait_q(input int n);
        for (int i = 0; i < 20 && got_q.size() < n; i++) @(negedge clk);
    endtask
    // compare the oldest stream word
    task automatic chk_wr(input logic [1:0] t, input logic [15:0] a, input logic [71:0] d,
        input logic [71:0] m, input logic p, input logic [2:0] h);
        wr_ent_t e;
        if (got_q.size() == 0) begin
            chk("write present", 72'h1, 72'h0);
            return;
        end
        e = got_q.pop_front();
        chk("target", 72'(t), 72'(e.t));
        chk("address", 72'(a), 72'(e.a));
        chk("data", d, e.d);
        chk("mask", m, e.m);
        chk("parallel", 72'(p), 72'(e.p));
        if (t == `TGT_SRAM) chk("sram high", 72'(h), 72'(e.h));
    endtask

    initial begin
        rst_n = 1'b0;
        wr_ready = 1'b1;
        dev_id = MY_ID;
        dq_bad = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("reset outputs", 72'h31, 72'({dq_oe_n, eot_oe_n, wv, busy, ovf, pr}));
        @(negedge clk) rst_n = 1'b1;
        // plain direct write with the all-ones reset mask
        host.single(0, `TGT_DATA, 0, 3'h0, 16'h1234, MY_ID, 4'h0, 3'h0, 72'h12_3456_789a_bcde_f012);
        wait_q(1);
        chk_wr(`TGT_DATA, 16'h1234, 72'h12_3456_789a_bcde_f012, `FULL_MASK, 0, 3'h0);
        // registers: mask reg 9, result reg 3, burst control, junk in bits 15:7
        host.single(0, `TGT_REG, 0, 3'h0, 16'hff89, MY_ID, 4'h0, 3'h0, PAT);
        host.single(0, `TGT_REG, 0, 3'h0, 16'hff93, MY_ID, 4'h0, 3'h0, 72'h00_0000_0000_0000_1234);
        host.single(0, `TGT_REG, 0, 3'h0, 16'hff98, MY_ID, 4'h0, 3'h0,
                    72'h00_0000_0000_0003_0100);
        chk("register writes stay internal", 72'h0, 72'(got_q.size()));
        // masked write through index 9, high index bit set
        host.single(0, `TGT_MASK, 0, 3'h0, 16'h0042, MY_ID, 4'h9, 3'h0, 72'hff_ffff_0000_ffff_0000);
        wait_q(1);
        chk_wr(`TGT_MASK, 16'h0042, 72'hff_ffff_0000_ffff_0000, PAT, 0, 3'h0);
        // indirect sram write: result reg 3 or low bus bits
        host.single(0, `TGT_SRAM, 1, 3'h3, 16'h0003, MY_ID, 4'h0, 3'h5, 72'h00_0000_0000_0000_abcd);
        wait_q(1);
        chk_wr(`TGT_SRAM, 16'h1237, 72'h00_0000_0000_0000_abcd, `FULL_MASK, 0, 3'h5);
        // foreign identifier refused, broadcast accepted
        host.single(0, `TGT_DATA, 0, 3'h0, 16'h0007, 5'h0b, 4'h0, 3'h0, 72'h00_0000_0000_0000_0001);
        repeat (8) @(negedge clk);
        chk("foreign id ignored", 72'h0, 72'(got_q.size()));
        host.single(0, `TGT_DATA, 0, 3'h0, 16'h0008, `ALL_DEVICES, 4'h0, 3'h0, 72'h0002);
        wait_q(1);
        chk_wr(`TGT_DATA, 16'h0008, 72'h00_0000_0000_0000_0002, `FULL_MASK, 0, 3'h0);
        // parallel write uses only bits 10:1
        host.single(1, `TGT_DATA, 0, 3'h0, 16'hffff, MY_ID, 4'h0, 3'h0, 72'h00_0000_0000_0000_0003);
        wait_q(1);
        chk_wr(`TGT_DATA, 16'h07fe, 72'h00_0000_0000_0000_0003, `FULL_MASK, 1, 3'h0);
        // burst of three into the mask array, address from burst control
        eot_q.delete();
        host.burst(`TGT_MASK, MY_ID, 4'h9, 3);
        wait_q(3);
        for (int i = 0; i < 3; i++) begin
            chk_wr(`TGT_MASK, 16'h0100 + 16'(i), host.word(i), PAT, 0, 0);
        end
        repeat (4) @(negedge clk);
        chk("eot count", 72'h3, 72'(eot_q.size()));
        if (eot_q.size() == 3) chk("eot pattern", 72'h2, 72'({eot_q[0], eot_q[1], eot_q[2]}));
        chk("eot released", 72'h1, 72'(eot_oe_n));
        // stalled consumer: two words held, third dropped, then drained
        @(negedge clk) wr_ready = 1'b0;
        for (int i = 0; i < 3; i++) begin
            host.single(0, `TGT_DATA, 0, 3'h0, 16'h0200 + 16'(i), MY_ID, 4'h0, 3'h0, 72'(i + 16));
        end
        repeat (6) @(negedge clk);
        chk("full, overflow, valid", 72'h3, 72'({pr, ovf, wv}));
        @(negedge clk) wr_ready = 1'b1;
        wait_q(2);
        for (int i = 0; i < 2; i++) begin
            chk_wr(`TGT_DATA, 16'h0200 + 16'(i), 72'(i + 16), `FULL_MASK, 0, 0);
        end
        repeat (4) @(negedge clk);
        chk("drained", 72'h0, 72'({got_q.size() != 0, wv}));
        chk("data bus never driven", 72'h0, 72'(dq_bad));
        wrap_up();
    end
endmodule
